//--- ccr_pkg.sv
package ccr_pkg;
    // ==========================================
    // register addresses on the special function bus
    localparam logic [7:0] CTRL_ADDR = 8'h9C;
    localparam logic [7:0] MODE_ADDR = 8'h9D;
    localparam logic [7:0] MUX_ADDR = 8'h9F;

    // ==========================================
    // values after reset
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h02;
    localparam logic [7:0] MUX_RESET = 8'hFF;

    // ==========================================
    // control register fields
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_OUT_BIT = 6;
    localparam int CTRL_RISE_FLAG_BIT = 5;
    localparam int CTRL_FALL_FLAG_BIT = 4;
    localparam int CTRL_HYST_POS_LSB = 2;
    localparam int CTRL_HYST_NEG_LSB = 0;

    // ==========================================
    // mode register fields
    localparam int MODE_RISE_IE_BIT = 5;
    localparam int MODE_FALL_IE_BIT = 4;
    localparam int MODE_RESP_LSB = 0;
    localparam logic [7:0] MODE_USED_MASK = 8'h33;

    // ==========================================
    // input mux register fields
    localparam int MUX_POS_LSB = 0;
    localparam int MUX_NEG_LSB = 4;
    localparam int MUX_NONE_BIT = 3;

    // ==========================================
    // crossbar enable bits that route comparator outputs
    localparam int XBAR_RAW_BIT = 5;
    localparam int XBAR_SYNC_BIT = 4;

    // ==========================================
    // response modes
    typedef enum logic [1:0] {
        RESP_FASTEST = 2'b00,
        RESP_FAST = 2'b01,
        RESP_SLOW = 2'b10,
        RESP_LOW_POWER = 2'b11
    } ccr_resp_e;
endpackage

//--- ccr_edge_if.sv
interface ccr_edge_if;
    logic cmpLevel;
    logic cmpSync;
    logic risePulse;
    logic fallPulse;

    modport ctrl (output cmpLevel, input cmpSync, input risePulse, input fallPulse);
    modport detect (input cmpLevel, output cmpSync, output risePulse, output fallPulse);
endinterface

//--- ccr_sync_edge.sv
module ccr_sync_edge (
    input wire logic clock,
    input wire logic resetn,
    ccr_edge_if.detect edge_port
);
    // ==========================================
    // two stage synchroniser and edge compare
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= edge_port.cmpLevel;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // edges compare only stage two against its own history
    assign edge_port.cmpSync = sync_q;
    assign edge_port.risePulse = sync_q & ~prev_q;
    assign edge_port.fallPulse = ~sync_q & prev_q;

    // ==========================================
    // checks
    property p_rise_delay;
        @(posedge clock) disable iff (!resetn)
        edge_port.risePulse |-> $past(edge_port.cmpLevel, 2) && !$past(edge_port.cmpLevel, 3);
    endproperty
    a_rise_delay: assert property (p_rise_delay) else $error("rise pulse not two cycles after level rise");

    property p_fall_delay;
        @(posedge clock) disable iff (!resetn)
        edge_port.fallPulse |-> !$past(edge_port.cmpLevel, 2) && $past(edge_port.cmpLevel, 3);
    endproperty
    a_fall_delay: assert property (p_fall_delay) else $error("fall pulse not two cycles after level fall");
endmodule

//--- ccr_comparator_regs.sv
// How it works
// - mode register bits 7-6 and 3-2 read as zero and ignore writes.
// - mode bit 5 lets rising-edge flags request an interrupt, and blocks them when zero.
// - mode bit 4 lets falling-edge flags request an interrupt, and blocks them when zero.
// - mode bits 1-0 pick one of four response settings, fastest at 0 and lowest power at 3, resetting to 2.
// - mux bits 3-0 pick positive input port 0 pins 0,2,4,6 then port 1 pins 0,2,4,6, none when bit 3 is set.
// - mux bits 7-4 pick negative input port 0 pins 1,3,5,7 then port 1 pins 1,3,5,7, none when bit 7 is set.
// - the mux register resets to all ones so no input pin is connected.
// - crossbar bit 5 drives the raw comparator output onto port 1 pin 4.
// - crossbar bit 4 drives the clock-synchronised output onto port 1 pin 5.
// - rising and falling output transitions set sticky flags that only software clears.
// - control bit 7 switches the comparator on when one and off when zero.
// - a disabled comparator shows logic low on the raw pin at once and on the synchronised pin two clocks later.
module ccr_comparator_regs (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    input wire logic rawCmp,
    input wire logic [7:0] crossbarEnable,
    output logic cmpEnable,
    output logic [1:0] responseMode,
    output logic [1:0] posHysteresis,
    output logic [1:0] negHysteresis,
    output logic [7:0] posPinSelect,
    output logic [7:0] negPinSelect,
    output logic rawPinOut,
    output logic rawPinOutEn,
    output logic syncPinOut,
    output logic syncPinOutEn,
    output logic cmpIrq
);
    // ==========================================
    // registers
    logic cmpEnable_q;
    logic riseFlag_q;
    logic riseFlag_d;
    logic fallFlag_q;
    logic fallFlag_d;
    logic [3:0] hyst_q;
    logic [7:0] mode_q;
    logic [7:0] mux_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    ccr_edge_if edgeBus ();

    ccr_sync_edge u_sync_edge (
        .clock(clock),
        .resetn(resetn),
        .edge_port(edgeBus.detect)
    );

    // ==========================================
    // address decode
    wire ctrlWrite = sfrWrite && (sfrAddr == ccr_pkg::CTRL_ADDR);
    wire modeWrite = sfrWrite && (sfrAddr == ccr_pkg::MODE_ADDR);
    wire muxWrite = sfrWrite && (sfrAddr == ccr_pkg::MUX_ADDR);

    wire riseIe = mode_q[ccr_pkg::MODE_RISE_IE_BIT];
    wire fallIe = mode_q[ccr_pkg::MODE_FALL_IE_BIT];
    wire [3:0] posSel = mux_q[ccr_pkg::MUX_POS_LSB +: 4];
    wire [3:0] negSel = mux_q[ccr_pkg::MUX_NEG_LSB +: 4];

    // ==========================================
    // comparator level, forced low while disabled
    assign edgeBus.cmpLevel = rawCmp & cmpEnable_q;
    wire cmpState = edgeBus.cmpSync;

    // hardware set beats a software clear in the same cycle
    assign riseFlag_d = edgeBus.risePulse | (ctrlWrite ? sfrWdata[ccr_pkg::CTRL_RISE_FLAG_BIT] : riseFlag_q);
    assign fallFlag_d = edgeBus.fallPulse | (ctrlWrite ? sfrWdata[ccr_pkg::CTRL_FALL_FLAG_BIT] : fallFlag_q);

    wire [7:0] ctrlView = {cmpEnable_q, cmpState, riseFlag_q, fallFlag_q, hyst_q};

    always_comb begin
        case (sfrAddr)
            ccr_pkg::CTRL_ADDR: rdata_d = ctrlView;
            ccr_pkg::MODE_ADDR: rdata_d = mode_q & ccr_pkg::MODE_USED_MASK;
            ccr_pkg::MUX_ADDR: rdata_d = mux_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cmpEnable_q <= ccr_pkg::CTRL_RESET[ccr_pkg::CTRL_EN_BIT];
            hyst_q <= ccr_pkg::CTRL_RESET[3:0];
            riseFlag_q <= 1'b0;
            fallFlag_q <= 1'b0;
        end else begin
            riseFlag_q <= riseFlag_d;
            fallFlag_q <= fallFlag_d;
            if (ctrlWrite) begin
                cmpEnable_q <= sfrWdata[ccr_pkg::CTRL_EN_BIT];
                hyst_q <= sfrWdata[3:0];
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mode_q <= ccr_pkg::MODE_RESET;
            mux_q <= ccr_pkg::MUX_RESET;
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
            if (modeWrite) begin
                mode_q <= sfrWdata & ccr_pkg::MODE_USED_MASK;
            end
            if (muxWrite) begin
                mux_q <= sfrWdata;
            end
        end
    end

    // ==========================================
    // input mux one-hot selects, pin order follows the select code
    // the analog side must see these pins set as analog inputs by software
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pin_sel
            assign posPinSelect[i] = !posSel[ccr_pkg::MUX_NONE_BIT] && (posSel[2:0] == 3'(i));
            assign negPinSelect[i] = !negSel[ccr_pkg::MUX_NONE_BIT] && (negSel[2:0] == 3'(i));
        end
    endgenerate

    // ==========================================
    // outputs
    assign sfrRdata = rdata_q;
    assign cmpEnable = cmpEnable_q;
    assign responseMode = mode_q[ccr_pkg::MODE_RESP_LSB +: 2];
    assign posHysteresis = hyst_q[ccr_pkg::CTRL_HYST_POS_LSB +: 2];
    assign negHysteresis = hyst_q[ccr_pkg::CTRL_HYST_NEG_LSB +: 2];

    // raw path is deliberately combinational: it must work with no clock running
    assign rawPinOut = rawCmp & cmpEnable_q;
    assign rawPinOutEn = !crossbarEnable[ccr_pkg::XBAR_RAW_BIT];
    assign syncPinOut = cmpState;
    assign syncPinOutEn = !crossbarEnable[ccr_pkg::XBAR_SYNC_BIT];

    assign cmpIrq = (riseFlag_q & riseIe) | (fallFlag_q & fallIe);

    // ==========================================
    // checks
    property p_mode_unused;
        @(posedge clock) disable iff (!resetn)
        ($past(sfrAddr) == ccr_pkg::MODE_ADDR) |-> (sfrRdata[7:6] == 2'b00) && (sfrRdata[3:2] == 2'b00);
    endproperty
    a_mode_unused: assert property (p_mode_unused) else $error("unused mode bits read non-zero");

    property p_rise_ie;
        @(posedge clock) disable iff (!resetn)
        !riseIe && !(fallFlag_q && fallIe) |-> !cmpIrq;
    endproperty
    a_rise_ie: assert property (p_rise_ie) else $error("rising flag raised irq while disabled");

    property p_fall_ie;
        @(posedge clock) disable iff (!resetn)
        edgeBus.fallPulse && fallIe && !modeWrite |=> cmpIrq;
    endproperty
    a_fall_ie: assert property (p_fall_ie) else $error("falling edge did not raise irq");

    property p_mode_write;
        @(posedge clock) disable iff (!resetn)
        modeWrite |=> responseMode == $past(sfrWdata[1:0]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("response mode not written");

    property p_pos_none;
        @(posedge clock) disable iff (!resetn)
        mux_q[3] |-> posPinSelect == 8'h00;
    endproperty
    a_pos_none: assert property (p_pos_none) else $error("positive pin selected while none");

    property p_neg_pick;
        @(posedge clock) disable iff (!resetn)
        !mux_q[7] |-> negPinSelect == (8'h01 << mux_q[6:4]);
    endproperty
    a_neg_pick: assert property (p_neg_pick) else $error("negative pin select wrong");

    property p_disabled_low;
        @(posedge clock) disable iff (!resetn)
        !cmpEnable_q ##2 !cmpEnable_q |-> !rawPinOut && !syncPinOut;
    endproperty
    a_disabled_low: assert property (p_disabled_low) else $error("disabled comparator drives high");

    property p_sync_pin;
        @(posedge clock) disable iff (!resetn)
        syncPinOut |-> $past(rawCmp, 2) && $past(cmpEnable_q, 2);
    endproperty
    a_sync_pin: assert property (p_sync_pin) else $error("sync pin not two cycles behind");

    property p_rise_sticky;
        @(posedge clock) disable iff (!resetn)
        riseFlag_q && !ctrlWrite |=> riseFlag_q;
    endproperty
    a_rise_sticky: assert property (p_rise_sticky) else $error("rising flag lost without clear");

    property p_rise_set;
        @(posedge clock) disable iff (!resetn)
        edgeBus.risePulse |=> riseFlag_q;
    endproperty
    a_rise_set: assert property (p_rise_set) else $error("rising flag not set");

    property p_fall_set;
        @(posedge clock) disable iff (!resetn)
        edgeBus.fallPulse |=> fallFlag_q;
    endproperty
    a_fall_set: assert property (p_fall_set) else $error("falling flag not set");

    property p_irq_rise;
        @(posedge clock) disable iff (!resetn)
        riseFlag_q && riseIe |-> cmpIrq;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("enabled rising flag without irq");

    c_rise_irq: cover property (@(posedge clock) disable iff (!resetn) edgeBus.risePulse && riseIe ##1 cmpIrq);
    c_fall_irq: cover property (@(posedge clock) disable iff (!resetn) edgeBus.fallPulse && fallIe ##1 cmpIrq);
    c_clear_race: cover property (@(posedge clock) disable iff (!resetn) edgeBus.risePulse && ctrlWrite);
    c_sync_out: cover property (@(posedge clock) disable iff (!resetn) syncPinOut && !syncPinOutEn);
endmodule

//--- ccr_core_model.sv
// ==========
// core side of the register bus: one byte per access, no wait states
module ccr_core_model (
    input wire logic clock,
    input wire logic [7:0] sfrRdata,
    output logic [7:0] sfrAddr,
    output logic sfrWrite,
    output logic [7:0] sfrWdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // chosen input pins must be set as analog and skipped in the crossbar by software
    initial begin
        sfrAddr = 8'h00;
        sfrWrite = 1'b0;
        sfrWdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfrAddr <= a;
        sfrWrite <= 1'b1;
        sfrWdata <= d;
        @(posedge clock);
        sfrWrite <= 1'b0;
        sfrWdata <= ~d;
    endtask
    // read data is registered, so it is taken one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        sfrAddr <= a;
        @(posedge clock);
        #1;
        d = sfrRdata;
    endtask
endmodule

//--- comparator_ctrl_regs_test.sv
module comparator_ctrl_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] mux; logic [7:0] pos; logic [7:0] neg;} ccr_row_s;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic rawCmp = 1'b0;
    logic [7:0] crossbarEnable = 8'h00;
    logic [7:0] sfrAddr, sfrWdata, sfrRdata, posPinSelect, negPinSelect;
    logic sfrWrite, cmpEnable, rawPinOut, rawPinOutEn, syncPinOut, syncPinOutEn, cmpIrq;
    logic [1:0] responseMode, posHysteresis, negHysteresis;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    ccr_row_s rows [10] = '{'{8'h00, 8'h01, 8'h01}, '{8'h17, 8'h80, 8'h02}, '{8'h26, 8'h40, 8'h04},
        '{8'h35, 8'h20, 8'h08}, '{8'h44, 8'h10, 8'h10}, '{8'h53, 8'h08, 8'h20}, '{8'h62, 8'h04, 8'h40},
        '{8'h71, 8'h02, 8'h80}, '{8'h8A, 8'h00, 8'h00}, '{8'h0C, 8'h00, 8'h01}};

    ccr_comparator_regs ccr_comparator_regs_inst (.clock, .resetn, .sfrAddr, .sfrWrite, .sfrWdata,
        .sfrRdata, .rawCmp, .crossbarEnable, .cmpEnable, .responseMode, .posHysteresis, .negHysteresis,
        .posPinSelect, .negPinSelect, .rawPinOut, .rawPinOutEn, .syncPinOut, .syncPinOutEn, .cmpIrq);
    ccr_core_model ccr_core_model_inst (.clock, .sfrRdata, .sfrAddr, .sfrWrite, .sfrWdata);

    // ==========
    // clock, timeout and report
    initial begin
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        ccr_core_model_inst.rd(a, d);
        chk(what, d, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ccr_core_model_inst.wr(a, d);
        // the write lands on this edge: let it settle before outputs are compared
        #1;
    endtask

    // ==========
    // tests
    initial begin
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        #1;
        chk("responseMode", 8'(responseMode), 8'h02);
        chk("posPinSelect", posPinSelect, 8'h00);
        chk("negPinSelect", negPinSelect, 8'h00);
        chk("rawPinOutEn", 8'(rawPinOutEn), 8'h01);
        rdchk("mode", ccr_pkg::MODE_ADDR, 8'h02);
        rdchk("mux", ccr_pkg::MUX_ADDR, 8'hFF);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(ccr_pkg::MUX_ADDR, rows[i].mux);
            rdchk("mux", ccr_pkg::MUX_ADDR, rows[i].mux);
            chk("posPinSelect", posPinSelect, rows[i].pos);
            chk("negPinSelect", negPinSelect, rows[i].neg);
        end
        $display("input select table done");
        for (int m = 0; m < 4; m++) begin
            wr(ccr_pkg::MODE_ADDR, 8'hCC | 8'(m));
            rdchk("mode", ccr_pkg::MODE_ADDR, 8'(m));
            chk("responseMode", 8'(responseMode), 8'(m));
        end
        wr(ccr_pkg::MODE_ADDR, 8'hFF);
        rdchk("mode", ccr_pkg::MODE_ADDR, 8'h33);
        wr(8'h9E, 8'h5A);
        rdchk("unmapped", 8'h9E, 8'h00);
        $display("mode register test done");
        // enable, then clear any flag left by power-up before watching edges
        wr(ccr_pkg::MODE_ADDR, 8'h00);
        wr(ccr_pkg::CTRL_ADDR, 8'h80);
        @(posedge clock);
        crossbarEnable <= 8'h30;
        settle(4);
        wr(ccr_pkg::CTRL_ADDR, 8'h80);
        chk("cmpEnable", 8'(cmpEnable), 8'h01);
        @(posedge clock);
        rawCmp <= 1'b1;
        settle(1);
        chk("syncPinOut early", 8'(syncPinOut), 8'h00);
        chk("rawPinOut", 8'(rawPinOut), 8'h01);
        chk("rawPinOutEn", 8'(rawPinOutEn), 8'h00);
        settle(1);
        chk("syncPinOut", 8'(syncPinOut), 8'h01);
        chk("syncPinOutEn", 8'(syncPinOutEn), 8'h00);
        settle(2);
        chk("cmpIrq masked", 8'(cmpIrq), 8'h00);
        rdchk("ctrl", ccr_pkg::CTRL_ADDR, 8'hE0);
        wr(ccr_pkg::MODE_ADDR, 8'h20);
        chk("cmpIrq rise", 8'(cmpIrq), 8'h01);
        wr(ccr_pkg::MODE_ADDR, 8'h10);
        chk("cmpIrq rise off", 8'(cmpIrq), 8'h00);
        wr(ccr_pkg::CTRL_ADDR, 8'h80);
        rdchk("ctrl cleared", ccr_pkg::CTRL_ADDR, 8'hC0);
        @(posedge clock);
        rawCmp <= 1'b0;
        settle(4);
        chk("cmpIrq fall", 8'(cmpIrq), 8'h01);
        rdchk("ctrl fall", ccr_pkg::CTRL_ADDR, 8'h90);
        wr(ccr_pkg::MODE_ADDR, 8'h20);
        chk("cmpIrq fall off", 8'(cmpIrq), 8'h00);
        $display("edge flag test done");
        // rise edge reaches the flag on the very edge that software clears it: the edge must win
        @(posedge clock);
        rawCmp <= 1'b1;
        @(posedge clock);
        wr(ccr_pkg::CTRL_ADDR, 8'h80);
        chk("cmpIrq race", 8'(cmpIrq), 8'h01);
        rdchk("ctrl race", ccr_pkg::CTRL_ADDR, 8'hE0);
        $display("clear race test done");
        wr(ccr_pkg::CTRL_ADDR, 8'h0B);
        settle(3);
        chk("cmpEnable", 8'(cmpEnable), 8'h00);
        chk("rawPinOut off", 8'(rawPinOut), 8'h00);
        chk("syncPinOut off", 8'(syncPinOut), 8'h00);
        chk("posHysteresis", 8'(posHysteresis), 8'h02);
        chk("negHysteresis", 8'(negHysteresis), 8'h03);
        // disabling drops the level, so a falling edge is flagged
        rdchk("ctrl disabled", ccr_pkg::CTRL_ADDR, 8'h1B);
        $display("disable test done");
        @(posedge clock);
        resetn <= 1'b0;
        settle(2);
        chk("responseMode reset", 8'(responseMode), 8'h02);
        chk("negPinSelect reset", negPinSelect, 8'h00);
        chk("posHysteresis reset", 8'(posHysteresis), 8'h00);
        @(posedge clock);
        resetn <= 1'b1;
        rdchk("mux reset", ccr_pkg::MUX_ADDR, 8'hFF);
        rdchk("ctrl reset", ccr_pkg::CTRL_ADDR, 8'h00);
        $display("mid-run reset test done");
        stop_test();
    end
endmodule
